// ### inc/wsc_pkg.sv
// Constants, register map and checksum function of the wheel sensor
// status and configuration block.
// Assumes a single 20 MHz clock domain.
package wsc_pkg;

    // Channel and word sizes
    localparam int CH_N       = 4;
    localparam int ADDR_W     = 7;
    localparam int REG_W      = 20;
    localparam int DATA_W     = 17;
    localparam int CRC_W      = 3;

    // Checksum generator x^3 + x + 1, leading bits inverted
    localparam logic [3:0] CRC_POLY     = 4'hB;
    localparam logic [2:0] CRC_PRE      = 3'h7;
    localparam logic [16:0] CRC_EX_DATA = 17'h00900;
    localparam logic [2:0] CRC_EX_SUM   = 3'h2;
    localparam logic [16:0] CRC_ZERO_DATA = 17'h00000;
    localparam logic [2:0] CRC_ZERO_SUM = 3'h6;

    // Register addresses
    localparam logic [6:0] ADDR_CFG_A    = 7'h01;
    localparam logic [6:0] ADDR_CFG_B    = 7'h02;
    localparam logic [6:0] ADDR_THR      = 7'h03;
    localparam logic [6:0] ADDR_LS_FAULT = 7'h04;
    localparam logic [6:0] ADDR_TEST     = 7'h05;
    localparam logic [6:0] ADDR_CTRL     = 7'h0A;
    localparam logic [6:0] ADDR_DATA0    = 7'h10;

    // Control register fields
    localparam int CTRL_W        = 6;
    localparam int CTRL_EN_LSB   = 0;
    localparam int CTRL_ACCESS_GRANT_A_BIT = 4;
    localparam int CTRL_INIT_BIT = 5;
    localparam logic [5:0] CTRL_RST = 6'h00;

    // Channel configuration fields, one ten-bit field per channel
    localparam int CFG_W         = 20;
    localparam int CFG_FIELD_W   = 10;
    localparam int CFG_TYPE_LSB  = 0;
    localparam int CFG_FIX_BIT   = 3;
    localparam int CFG_STANDSTILL_OUTPUT_DISABLE_BIT = 4;
    localparam int CFG_PT_BIT    = 5;
    localparam int CFG_DGL_LSB   = 6;
    localparam logic [19:0] CFG_RST = 20'h00000;
    localparam logic [1:0] SENS_PWM2 = 2'h2;

    // Threshold values
    localparam int THR_W    = 18;
    localparam int THR1_LSB = 0;
    localparam int THR2_LSB = 10;
    localparam logic [17:0] THR_RST = 18'h0D033;

    // Output test register
    localparam int TEST_W       = 9;
    localparam int TEST_PAT_BIT = 0;
    localparam int TEST_SEL_LSB = 2;
    localparam logic [8:0] TEST_RST = 9'h001;

    // Sensor data word fields
    localparam int D_LKG_BIT   = 7;
    localparam int D_STB_BIT   = 8;
    localparam int D_STG_BIT   = 9;
    localparam int D_EMPTY_BIT = 3;
    localparam int D_LCID_LSB  = 12;
    localparam int D_FLT_BIT   = 15;
    localparam logic [16:0] DATA_RST = 17'h08008;

    // Low-side fault flags
    localparam int LSF_W       = 8;
    localparam int LSF_STG_LSB = 0;
    localparam int LSF_OC_LSB  = 4;
    localparam logic [7:0] LSF_RST = 8'h00;

    // Serial frame: write bit, address, four pad bits, data
    localparam int FRAME_BITS = 32;
    localparam int HDR_BITS   = 12;
    localparam int FRM_WR_BIT = 31;
    localparam int FRM_AD_MSB = 30;
    localparam logic [2:0] SPI_IDLE = 3'h2;

    // Filter times, least values, rounded up to whole cycles
    localparam int CLK_MHZ      = 20;
    localparam int T_HS_FILT_NS = 550000;
    localparam int T_STB_NS     = 10000;
    localparam int T_LKG_NS     = 10000;
    localparam int HS_FILT_CYC  = (T_HS_FILT_NS * CLK_MHZ + 999) / 1000;
    localparam int STB_CYC      = (T_STB_NS * CLK_MHZ + 999) / 1000;
    localparam int LKG_CYC      = (T_LKG_NS * CLK_MHZ + 999) / 1000;
    localparam int FILT_CNT_W   = 16;

    // Leading inverted bits first, then data bit 0 upward
    function automatic logic [2:0] crc_calc(input logic [16:0] d);
        logic [2:0]  c;
        logic [19:0] m;
        logic        fb;
        c = 3'h0;
        m = {d, CRC_PRE};
        for (int i = 0; i < DATA_W + CRC_W; i++) begin
            fb = c[2] ^ m[i];
            c  = {c[1:0], 1'b0} ^ (fb ? CRC_POLY[2:0] : 3'h0);
        end
        return c;
    endfunction : crc_calc

endpackage : wsc_pkg

// ### verilog/wsc_status_config.sv
// Register side of a four-channel wheel speed sensor interface: serial
// register port, sensor data words with checksum, fault filters, config.
// Assumes comparator levels and the serial pins are asynchronous, decoder
// signals are on clk, and the serial clock is well below clk / 8.
// Notes on behaviour
// [R01] Checksum is three bits with generator x^3 + x + 1 (code 0xB).
// [R02] Checksum seed bits are all ones.
// [R03] Checksum covers the 17 data bits, least significant bit first.
// [R04] Word is shifted, flipped, first three bits inverted, then divided.
// [R05] Each checksum bit is a pure XOR chain of seed and data bits.
// [R06] Checksum sits in bits 17 to 19, computed over bits 0 to 16.
// [R07] After reset every data word shows fault flag and empty buffer.
// [R08] Bit 15 is the fault flag; lower bits then carry fault detail.
// [R09] In fault layout bit 3 is empty buffer, resetting to one.
// [R10] Channels 2 to 4 data words are read-only at 0x11, 0x12, 0x13.
// [R11] High-side ground short flagged after about 550 us over limit.
// [R12] Battery short flagged after overvoltage lasts 10 to 15 us.
// [R13] Battery leakage flagged after high current lasts 10 to 15 us.
// [R14] Low-side flags: overcurrent bits 4-7, ground short 0-3, reset 0.
// [R15] Low-side fault register is read-only and clears when read.
// [R16] Host sets the access grant before writing configuration.
// [R17] Channel 1 config in bits 0-9: type, method, standstill, pass, time.
// [R18] Channel 2 uses bits 10-19; channels 3-4 a second register.
// [R19] Host programs threshold values when fixed method is selected.
// [R20] A speed output is driven only when its enable bit is set, except an output selected for test.
// [R21] Host clears the access grant when configuration is done.
// [R22] Control write without access grant resets it, outputs off.
// [R23] With diagnostic bit set, selected output shows the static pattern.
// [R24] Selected output is high by default when the test starts.
// [R25] Standstill disable acts only for two-edge duty-cycle sensors.
// [R26] Checksum follows any change of the data bits at once.
// [R27] Clearing the diagnostic bit returns outputs to speed control.
`timescale 1ns/1ps
module wsc_status_config #(
    parameter int HS_FILT_CYC = wsc_pkg::HS_FILT_CYC,
    parameter int STB_CYC     = wsc_pkg::STB_CYC,
    parameter int LKG_CYC     = wsc_pkg::LKG_CYC
) (
    // Clock and reset
    input  wire logic                                      clk,
    input  wire logic                                      nrst,
    // Serial register port
    input  wire logic                                      spi_sclk,
    input  wire logic                                      spi_cs_n,
    input  wire logic                                      spi_mosi,
    output logic                                           spi_miso,
    output logic                                           spi_miso_oe,
    // Decoder side
    input  wire logic [wsc_pkg::CH_N-1:0][wsc_pkg::DATA_W-1:0] chan_data,
    input  wire logic [wsc_pkg::CH_N-1:0]                  chan_load,
    input  wire logic [wsc_pkg::CH_N-1:0]                  speed_in,
    input  wire logic [wsc_pkg::CH_N-1:0]                  standstill_in,
    // Comparator levels
    input  wire logic [wsc_pkg::CH_N-1:0]                  hs_limit_raw,
    input  wire logic [wsc_pkg::CH_N-1:0]                  stb_over_raw,
    input  wire logic [wsc_pkg::CH_N-1:0]                  lkg_high_raw,
    input  wire logic [wsc_pkg::CH_N-1:0]                  ls_oc_raw,
    input  wire logic [wsc_pkg::CH_N-1:0]                  ls_stg_raw,
    // Channel outputs and decoded configuration
    output logic [wsc_pkg::CH_N-1:0]                       speed_output_pin,
    output wire logic [wsc_pkg::CH_N-1:0][1:0]             sensor_type,
    output wire logic [wsc_pkg::CH_N-1:0]            fixed_threshold_select,
    output wire logic [wsc_pkg::CH_N-1:0]         standstill_output_disable,
    output wire logic [wsc_pkg::CH_N-1:0]              pass_through_enable,
    output wire logic [wsc_pkg::CH_N-1:0][3:0]         deglitch_time,
    output wire logic [7:0]                            thr1_offset,
    output wire logic [7:0]                            thr2_offset
);
    import wsc_pkg::*;

    localparam int SYN_W = 5 * CH_N + 3;

    logic [SYN_W-1:0]          syn1_reg;
    logic [SYN_W-1:0]          syn2_reg;
    logic                      mosi_s;
    logic                      cs_s;
    logic                      sclk_s;
    logic [2:0][CH_N-1:0]      flt_lvl;
    logic [CH_N-1:0]           oc_s;
    logic [CH_N-1:0]           stg_s;
    wire  [2:0][CH_N-1:0]      flt_evt;
    wire  [CH_N-1:0][REG_W-1:0] data_word;

    // Two-stage synchronisers for every pin-side level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syn1_reg <= {{(5 * CH_N){1'b0}}, SPI_IDLE};
            syn2_reg <= {{(5 * CH_N){1'b0}}, SPI_IDLE};
        end else begin
            syn1_reg <= {ls_stg_raw, ls_oc_raw, lkg_high_raw, stb_over_raw,
                         hs_limit_raw, spi_sclk, spi_cs_n, spi_mosi};
            syn2_reg <= syn1_reg;
        end
    end

    assign mosi_s  = syn2_reg[0];
    assign cs_s    = syn2_reg[1];
    assign sclk_s  = syn2_reg[2];
    assign flt_lvl = syn2_reg[3 +: 3 * CH_N];
    assign oc_s    = syn2_reg[3 + 3 * CH_N +: CH_N];
    assign stg_s   = syn2_reg[3 + 4 * CH_N +: CH_N];

    // Serial slave: sample on rising clock, shift out on falling
    logic                      sclk_d_reg;
    logic [FRAME_BITS-1:0]     rx_reg;
    logic [FRAME_BITS-1:0]     rx_next;
    logic [5:0]                cnt_reg;
    logic [5:0]                cnt_next;
    logic [REG_W-1:0]          tx_reg;
    logic [REG_W-1:0]          tx_next;
    logic                      miso_next;
    logic                      rd_stb;
    logic                      wr_stb;
    logic [ADDR_W-1:0]         rd_addr;
    logic [ADDR_W-1:0]         wr_addr;
    logic [REG_W-1:0]          wr_data;
    logic [REG_W-1:0]          rd_data;

    assign rd_addr     = rx_reg[HDR_BITS-3 -: ADDR_W];
    assign wr_addr     = rx_reg[FRM_AD_MSB -: ADDR_W];
    assign wr_data     = rx_reg[REG_W-1:0];
    assign spi_miso_oe = ~cs_s;

    always_comb begin
        rx_next   = rx_reg;
        cnt_next  = cnt_reg;
        tx_next   = tx_reg;
        miso_next = spi_miso;
        rd_stb    = 1'b0;
        wr_stb    = 1'b0;
        if (cs_s) begin
            cnt_next  = 6'h00;
            miso_next = 1'b0;
            // Only a complete frame writes; short frames are dropped
            wr_stb    = (cnt_reg == 6'(FRAME_BITS)) & rx_reg[FRM_WR_BIT];
        end else begin
            if (sclk_s & ~sclk_d_reg) begin
                rx_next = {rx_reg[FRAME_BITS-2:0], mosi_s};
                if (cnt_reg != 6'(FRAME_BITS)) begin
                    cnt_next = cnt_reg + 6'h01;
                end
                if (cnt_reg == 6'(HDR_BITS - 1)) begin
                    tx_next = rd_data;
                    rd_stb  = ~rx_reg[HDR_BITS-2];
                end
            end
            if (~sclk_s & sclk_d_reg & (cnt_reg >= 6'(HDR_BITS))) begin
                miso_next = tx_reg[REG_W-1];
                tx_next   = {tx_reg[REG_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_d_reg <= 1'b0;
            rx_reg     <= '0;
            cnt_reg    <= 6'h00;
            tx_reg     <= '0;
            spi_miso   <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            rx_reg     <= rx_next;
            cnt_reg    <= cnt_next;
            tx_reg     <= tx_next;
            spi_miso   <= miso_next;
        end
    end

    // Control, configuration, thresholds, test and low-side flags
    logic [CTRL_W-1:0]         ctrl_reg;
    logic [CTRL_W-1:0]         ctrl_next;
    logic [1:0][CFG_W-1:0]     cfg_reg;
    logic [1:0][CFG_W-1:0]     cfg_next;
    logic [THR_W-1:0]          thr_reg;
    logic [THR_W-1:0]          thr_next;
    logic [TEST_W-1:0]         test_reg;
    logic [TEST_W-1:0]         test_next;
    logic [LSF_W-1:0]          lsf_reg;
    logic [LSF_W-1:0]          lsf_next;
    logic                      init;
    logic                      access_grant_a;

    assign init = ctrl_reg[CTRL_INIT_BIT];
    assign access_grant_a = ctrl_reg[CTRL_ACCESS_GRANT_A_BIT];

    always_comb begin
        ctrl_next = ctrl_reg;
        cfg_next  = cfg_reg;
        thr_next  = thr_reg;
        test_next = test_reg;
        if (wr_stb) begin
            case (wr_addr)
                ADDR_CTRL: begin
                    if (init) begin
                        ctrl_next = wr_data[CTRL_W-1:0];
                    end else if (wr_data[CTRL_INIT_BIT]
                                 | wr_data[CTRL_ACCESS_GRANT_A_BIT]) begin
                        ctrl_next[CTRL_INIT_BIT] = wr_data[CTRL_INIT_BIT];
                        ctrl_next[CTRL_ACCESS_GRANT_A_BIT] = wr_data[CTRL_ACCESS_GRANT_A_BIT];
                    end else begin
                        ctrl_next = CTRL_RST; // R22
                    end
                end
                ADDR_CFG_A: if (init) cfg_next[0] = wr_data; // R16 R17
                ADDR_CFG_B: if (init) cfg_next[1] = wr_data; // R18
                ADDR_THR:   if (init) thr_next = wr_data[THR_W-1:0]; // R19
                ADDR_TEST:  if (access_grant_a) test_next = wr_data[TEST_W-1:0]; // R23
                default: ;
            endcase
        end
        // Test opens with the pattern high
        if (ctrl_next[CTRL_ACCESS_GRANT_A_BIT] & ~access_grant_a) begin
            test_next[TEST_PAT_BIT] = 1'b1; // R24
        end
        // Clear on read, but a new event in the same cycle survives
        lsf_next = (rd_stb && rd_addr == ADDR_LS_FAULT) ? LSF_RST
                                                        : lsf_reg; // R15
        lsf_next[LSF_OC_LSB +: CH_N]  = lsf_next[LSF_OC_LSB +: CH_N] | oc_s;
        lsf_next[LSF_STG_LSB +: CH_N] = lsf_next[LSF_STG_LSB +: CH_N]
                                        | stg_s; // R14
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RST;
            cfg_reg  <= {CFG_RST, CFG_RST};
            thr_reg  <= THR_RST;
            test_reg <= TEST_RST;
            lsf_reg  <= LSF_RST;
        end else begin
            ctrl_reg <= ctrl_next;
            cfg_reg  <= cfg_next;
            thr_reg  <= thr_next;
            test_reg <= test_next;
            lsf_reg  <= lsf_next;
        end
    end

    assign thr1_offset = thr_reg[THR1_LSB +: 8];
    assign thr2_offset = thr_reg[THR2_LSB +: 8];

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rd_data = '0;
        case (rd_addr)
            ADDR_CTRL:     rd_data = REG_W'(ctrl_reg);
            ADDR_CFG_A:    rd_data = cfg_reg[0];
            ADDR_CFG_B:    rd_data = cfg_reg[1];
            ADDR_THR:      rd_data = REG_W'(thr_reg);
            ADDR_TEST:     rd_data = REG_W'(test_reg);
            ADDR_LS_FAULT: rd_data = REG_W'(lsf_reg);
            default: begin
                if (rd_addr[ADDR_W-1:2] == ADDR_DATA0[ADDR_W-1:2]) begin
                    rd_data = data_word[rd_addr[1:0]]; // R10
                end
            end
        endcase
    end

    // Per-channel fault filters, data words and configuration decode
    for (genvar k = 0; k < CH_N; k++) begin : g_ch
        logic [DATA_W-1:0]     data_reg;
        logic [DATA_W-1:0]     data_next;
        logic [CFG_FIELD_W-1:0] field;

        for (genvar j = 0; j < 3; j++) begin : g_flt
            localparam int LIM = (j == 0) ? HS_FILT_CYC :
                                 (j == 1) ? STB_CYC : LKG_CYC;
            logic [FILT_CNT_W-1:0] cnt_reg;
            logic [FILT_CNT_W-1:0] cnt_next;
            // Level must hold unbroken; any drop restarts the count
            always_comb begin
                cnt_next = cnt_reg;
                if (!flt_lvl[j][k]) begin
                    cnt_next = '0;
                end else if (cnt_reg != FILT_CNT_W'(LIM)) begin
                    cnt_next = cnt_reg + 1'b1; // R11 R12 R13
                end
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    cnt_reg <= '0;
                end else begin
                    cnt_reg <= cnt_next;
                end
            end
            assign flt_evt[j][k] = flt_lvl[j][k]
                                   & (cnt_reg == FILT_CNT_W'(LIM - 1));
        end

        always_comb begin
            data_next = data_reg;
            if (chan_load[k]) begin
                data_next = chan_data[k];
                data_next[D_LCID_LSB +: 2] = 2'(k);
            end
            // Fault events override a same-cycle load
            if (|{flt_evt[0][k], flt_evt[1][k], flt_evt[2][k]}) begin
                data_next[D_FLT_BIT] = 1'b1; // R08
            end
            if (flt_evt[0][k]) data_next[D_STG_BIT] = 1'b1; // R11
            if (flt_evt[1][k]) data_next[D_STB_BIT] = 1'b1; // R12
            if (flt_evt[2][k]) data_next[D_LKG_BIT] = 1'b1; // R13
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                data_reg <= DATA_RST
                            | (DATA_W'(k) << D_LCID_LSB); // R07 R09
            end else begin
                data_reg <= data_next;
            end
        end

        // Checksum is combinational, so reads never see a stale value
        assign data_word[k] = {crc_calc(data_reg), data_reg}; // R01-R06 R26

        assign field = cfg_reg[k / 2][(k % 2) * CFG_FIELD_W +: CFG_FIELD_W];
        assign sensor_type[k]  = field[CFG_TYPE_LSB +: 2]; // R17 R18
        assign fixed_threshold_select[k]    = field[CFG_FIX_BIT];
        assign standstill_output_disable[k] = field[CFG_STANDSTILL_OUTPUT_DISABLE_BIT];
        assign pass_through_enable[k]       = field[CFG_PT_BIT];
        assign deglitch_time[k] = field[CFG_DGL_LSB +: 4];
    end

    // Channel outputs, registered
    logic [CH_N-1:0] spd_next;
    logic [CH_N-1:0] test_sel;
    logic [CH_N-1:0] ss_block;

    assign test_sel = test_reg[TEST_SEL_LSB +: CH_N];

    always_comb begin
        for (int k = 0; k < CH_N; k++) begin
            ss_block[k] = standstill_output_disable[k] & standstill_in[k]
                          & (sensor_type[k] == SENS_PWM2); // R25
            if (access_grant_a & test_sel[k]) begin
                spd_next[k] = test_reg[TEST_PAT_BIT]; // R23
            end else begin
                spd_next[k] = ctrl_reg[CTRL_EN_LSB + k] & speed_in[k]
                              & ~ss_block[k]; // R20 R27
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            speed_output_pin <= '0;
        end else begin
            speed_output_pin <= spd_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_quiet;
        !access_grant_a && ctrl_reg[CTRL_EN_LSB +: CH_N] == '0;
    endsequence
    sequence s_test0;
        access_grant_a && test_sel[0];
    endsequence

    property p_crc_example;
        data_word[0][DATA_W-1:0] == CRC_EX_DATA
            |-> data_word[0][REG_W-1:DATA_W] == CRC_EX_SUM;
    endproperty
    a_crc_example: assert property (p_crc_example) // R04
        else $error("checksum of example word wrong");
    property p_crc_seed;
        data_word[0][DATA_W-1:0] == CRC_ZERO_DATA
            |-> data_word[0][REG_W-1:DATA_W] == CRC_ZERO_SUM;
    endproperty
    a_crc_seed: assert property (p_crc_seed) // R02
        else $error("checksum of zero word wrong");
    property p_reset_state;
        $rose(nrst) |-> data_word[2][D_FLT_BIT] && data_word[2][D_EMPTY_BIT];
    endproperty
    a_reset_state: assert property (p_reset_state) // R07
        else $error("data word not in empty fault state after reset");
    property p_read_clear;
        rd_stb && rd_addr == ADDR_LS_FAULT && !(|{oc_s, stg_s})
            |=> lsf_reg == LSF_RST;
    endproperty
    a_read_clear: assert property (p_read_clear) // R15
        else $error("low-side flags not cleared by read");
    property p_set_wins;
        |oc_s |=> (lsf_reg[LSF_OC_LSB +: CH_N] & $past(oc_s)) == $past(oc_s);
    endproperty
    a_set_wins: assert property (p_set_wins) // R14
        else $error("overcurrent event lost");
    property p_ctrl_guard;
        wr_stb && wr_addr == ADDR_CTRL && !init && !wr_data[CTRL_INIT_BIT]
            && !wr_data[CTRL_ACCESS_GRANT_A_BIT] |=> ctrl_reg == CTRL_RST ##1 s_quiet;
    endproperty
    a_ctrl_guard: assert property (p_ctrl_guard) // R22
        else $error("unguarded control write did not reset");
    property p_cfg_lock;
        wr_stb && wr_addr == ADDR_CFG_A && !init |=> $stable(cfg_reg);
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) // R17
        else $error("configuration changed without access grant");
    property p_out_gate;
        s_quiet ##1 s_quiet |-> speed_output_pin == '0;
    endproperty
    a_out_gate: assert property (p_out_gate) // R20
        else $error("speed output driven while disabled");
    property p_test_default;
        $rose(access_grant_a) |-> test_reg[TEST_PAT_BIT];
    endproperty
    a_test_default: assert property (p_test_default) // R24
        else $error("test pattern not high at test start");
    property p_test_drive;
        s_test0 ##1 s_test0 |-> speed_output_pin[0] == $past(test_reg[0]);
    endproperty
    a_test_drive: assert property (p_test_drive) // R23
        else $error("tested output does not follow pattern");
    property p_stb_filter;
        $rose(flt_lvl[1][2]) |-> (!flt_evt[1][2]) [*7];
    endproperty
    a_stb_filter: assert property (p_stb_filter) // R12
        else $error("battery short flagged without deglitch");
    property p_hs_flag;
        flt_evt[0][1] |=> data_word[1][D_STG_BIT] && data_word[1][D_FLT_BIT];
    endproperty
    a_hs_flag: assert property (p_hs_flag) // R11
        else $error("ground short event not flagged");

endmodule : wsc_status_config

// ### tb/wsc_host.sv
// Host model: 32-bit mode 0 serial frames, MSB first.
// Assumes clk is the device clock; sclk half period is five clk.
`timescale 1ns/1ps
module wsc_host (
    // Clock
    input  wire logic        clk,
    // Serial pins
    output logic             sclk,
    output logic             cs_n,
    output logic             mosi,
    input  wire logic        miso,
    // Read result
    output logic             rd_done,
    output logic [19:0]      rd_data
);
    initial {sclk, cs_n, mosi, rd_done, rd_data} = 24'h400000;

    task automatic xfer(input logic wr, input logic [6:0] a,
                        input logic [19:0] d);
        logic [31:0] f;
        f = {wr, a, 4'h0, d};
        cs_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi = f[i];
            repeat (5) @(posedge clk);
            #2 sclk = 1'b1;
            if (i < 20) rd_data = {rd_data[18:0], miso};
            repeat (5) @(posedge clk);
            #2 sclk = 1'b0;
        end
        repeat (5) @(posedge clk);
        // Released line must not keep its last bit
        #2 {cs_n, mosi} = {1'b1, ~mosi};
        rd_done = !wr;
        @(posedge clk);
        #2 rd_done = 1'b0;
        repeat (5) @(posedge clk);
        #2;
    endtask : xfer
endmodule : wsc_host

// ### tb/testbench.sv
// Top bench: host reads checked through a queue, pins checked directly.
// Assumes short filter counts so fault events come within tens of cycles.
`timescale 1ns/1ps
module testbench;
    import wsc_pkg::*;
    logic             clk, nrst, sclk, cs_n, mosi, miso, rd_done;
    logic [19:0]      rd_data, v, exp_q[$];
    logic [3:0][16:0] cdata;
    logic [3:0]       load, spd, hs, stb, lkg, oc, high_side_ground_short, pin;
    logic [3:0]       ss, fix, ssd, pte;
    logic [3:0][1:0]  styp;
    logic [3:0][3:0]  dgl;
    logic [7:0]       t1, t2;
    logic [16:0]      rnd, d;
    int               n_fail = 0, checks = 0;

    wsc_host u_wsc_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .rd_done(rd_done), .rd_data(rd_data));
    wsc_status_config #(.HS_FILT_CYC(20), .STB_CYC(8), .LKG_CYC(8))
    u_wsc_status_config (.clk(clk), .nrst(nrst), .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(),
        .chan_data(cdata), .chan_load(load), .speed_in(spd),
        .standstill_in(ss), .hs_limit_raw(hs), .stb_over_raw(stb),
        .lkg_high_raw(lkg), .ls_oc_raw(oc), .ls_stg_raw(high_side_ground_short),
        .speed_output_pin(pin), .sensor_type(styp),
        .fixed_threshold_select(fix), .standstill_output_disable(ssd),
        .pass_through_enable(pte), .deglitch_time(dgl), .thr1_offset(t1),
        .thr2_offset(t2));

    always #25 clk = ~clk;

    function automatic logic [19:0] dw(input logic [16:0] x);
        logic [19:0] m;
        logic [2:0]  r;
        m = {x, 3'h7};
        r = 3'h0;
        for (int i = 0; i < 20; i++)
            r = {r[1:0], 1'b0} ^ ((r[2] ^ m[i]) ? 3'h3 : 3'h0);
        return {r, x};
    endfunction : dw

    function automatic logic [16:0] lfsr(input logic [16:0] x);
        return {x[15:0], x[16] ^ x[13]};
    endfunction : lfsr

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    task automatic chk(input logic [19:0] s, input logic [19:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk

    task automatic rd(input logic [6:0] a, input logic [19:0] e);
        exp_q.push_back(e);
        u_wsc_host.xfer(1'b0, a, 20'h00000);
    endtask : rd

    task automatic wr(input logic [6:0] a, input logic [19:0] e);
        u_wsc_host.xfer(1'b1, a, e);
    endtask : wr

    task automatic ld(input logic [16:0] x);
        cdata[0] = x;
        load = 4'h1;
        step(1);
        load = 4'h0;
    endtask : ld

    task automatic end_sim;
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    always @(posedge clk) if (rd_done) chk(rd_data, exp_q.pop_front());

    initial begin
        #2000000;
        n_fail++;
        end_sim();
    end

    initial begin
        {clk, nrst, cdata, load, spd, hs, stb, lkg, oc, high_side_ground_short, ss} = '0;
        rnd = 17'h14DC1;
        step(12);
        nrst = 1'b1;
        step(4);
        for (int k = 0; k < 4; k++) begin
            d = 17'h08008 | 17'(k << 12);
            rd(ADDR_DATA0 + 7'(k), dw(d));
        end
        ld(CRC_ZERO_DATA);
        rd(ADDR_DATA0, {CRC_ZERO_SUM, CRC_ZERO_DATA});
        ld(17'h00900);
        rd(ADDR_DATA0, 20'h40900);
        rnd = lfsr(rnd);
        ld(rnd);
        rd(ADDR_DATA0, dw(rnd & 17'h1CFFF));
        rd(7'h7F, 20'h00000);
        rnd = lfsr(rnd);
        {oc, high_side_ground_short} = rnd[7:0] | 8'h81;
        step(5);
        {oc, high_side_ground_short} = 8'h00;
        rd(ADDR_LS_FAULT, {12'h000, rnd[7:0] | 8'h81});
        rd(ADDR_LS_FAULT, 20'h00000);
        {hs, stb, lkg} = 12'h248;
        step(30);
        for (int k = 1; k < 4; k++) begin
            d = 17'h08008 | 17'(k << 12) | (17'h00400 >> k);
            rd(ADDR_DATA0 + 7'(k), dw(d));
        end
        wr(ADDR_CTRL, 20'h00020);
        rnd = lfsr(rnd);
        v = {rnd[2:0], rnd};
        wr(ADDR_CFG_A, v);
        wr(ADDR_CFG_B, 20'h04412);
        wr(ADDR_THR, v);
        chk(20'(styp), 20'({4'h6, v[11:10], v[1:0]}));
        chk(20'(dgl[1:0]), 20'({v[19:16], v[9:6]}));
        chk(20'({pte, fix}), 20'({v[15], v[5], 2'h0, v[13], v[3]}));
        chk(20'(ssd), 20'({2'h3, v[14], v[4]}));
        chk(20'({t2, t1}), 20'({v[17:10], v[7:0]}));
        rd(ADDR_CFG_A, v);
        wr(ADDR_CTRL, 20'h0002F);
        spd = rnd[3:0];
        step(3);
        chk(20'(pin), 20'(spd));
        ss = 4'hF;
        step(3);
        chk(20'(pin), 20'(spd & 4'hB));
        ss = 4'h0;
        wr(ADDR_CTRL, 20'h0000F);
        wr(ADDR_CFG_A, ~v);
        rd(ADDR_CFG_A, v);
        chk(20'(pin), 20'(spd));
        wr(ADDR_CTRL, 20'h00001);
        rd(ADDR_CTRL, 20'h00000);
        chk(20'(pin), 20'h00000);
        wr(ADDR_CTRL, 20'h00030);
        wr(ADDR_CTRL, 20'h0003F);
        spd = 4'hF;
        wr(ADDR_TEST, 20'h00004);
        step(3);
        chk(20'(pin), 20'h0000E);
        wr(ADDR_CTRL, 20'h0002F);
        step(3);
        chk(20'(pin), 20'h0000F);
        spd = 4'h0;
        wr(ADDR_CTRL, 20'h0003F);
        step(3);
        chk(20'(pin), 20'h00001);
        end_sim();
    end
endmodule : testbench
